// file: hardware_breakpoint_unit.sv
// Hardware breakpoint unit: comparators, privilege gating, status, exception and trigger.
// Assumes pipeline inputs and the coprocessor register port are on MCLK.
`timescale 1ns/100ps
`include "hwbp_defs.svh"

// Notes on behaviour
// - Bit 21 enables data breaks in user mode.
// - Bit 20 enables data breaks in supervisor mode.
// - Bit 19 enables data breaks, kernel, no exception.
// - Bit 18 enables data breaks in exception level.
// - Bit 17 lets instruction breaks fire trigger.
// - Bit 16 lets data breaks fire trigger.
// - Bit 15 suppresses exception, trigger still fires.
// - Bits 14 to 3 read as zero.
// - Bit 2 flags store data break, writable.
// - Bit 1 flags load data break, writable.
// - Bit 0 flags instruction break, writable.
// - Masked instruction compare equals masked fetch PC.
// - Instruction compare and mask low bits zero.
// - Masked data compare equals masked access address.
// - Masked value compare equals masked data low word.
// - Value qualification needs address and value match.
// - Value compare uses low 32 data bits.
// - Late load value break waits outside level two.
// - Data address compare and mask are 32-bit.
// - Trigger output stays high two cycles.
// - Bits 31, 30, 29 enable classes; reset zero.
// - Breakpoint exception masked in level two and by bit 15.
module hardware_breakpoint_unit (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic REG_WRITE,
   input wire logic REG_READ,
   input wire logic [2:0] REG_SELECT,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   input wire logic FETCH_VALID,
   input wire logic [31:0] FETCH_PC,
   input wire logic LOAD_VALID,
   input wire logic STORE_VALID,
   input wire logic [31:0] ACCESS_ADDR,
   input wire logic [63:0] STORE_DATA,
   input wire logic LOAD_DATA_VALID,
   input wire logic [31:0] LOAD_ADDR,
   input wire logic [63:0] LOAD_DATA,
   input wire logic [1:0] PRIV_MODE,
   input wire logic EXCEPTION_LEVEL_FLAG,
   input wire logic ERROR_LEVEL_FLAG,
   input wire logic LEVEL2_MODE,
   output logic BREAK_EXCEPTION,
   output logic PROBE_TRIGGER_OUT
);
   logic [31:0] bp_control_reg;
   logic [31:0] instr_addr_compare;
   logic [31:0] instr_addr_mask;
   logic [31:0] data_addr_compare;
   logic [31:0] data_addr_mask;
   logic [31:0] data_value_compare;
   logic [31:0] data_value_mask;
   logic [1:0] trigger_count;
   hwbp_pkg::pend_state_t pend_state;

   // Returns one when the enable for the current privilege mode, or for exception level, is set; zero in error level.
   function automatic logic mode_enabled(input logic user_en, input logic sup_en,
                                         input logic kern_en, input logic exc_en,
                                         input logic [1:0] mode, input logic exc_level,
                                         input logic err_level);
      logic hit;
      hit = 1'b0;
      if (err_level) begin
         hit = 1'b0;
      end else if (exc_level) begin
         hit = exc_en;
      end else begin
         case (mode)
            hwbp_pkg::MODE_USER: hit = user_en;
            hwbp_pkg::MODE_SUPERVISOR: hit = sup_en;
            hwbp_pkg::MODE_KERNEL: hit = kern_en;
            default: hit = 1'b0;
         endcase
      end
      return hit;
   endfunction

   // Returns one when two words agree under a mask.
   function automatic logic masked_equal(input logic [31:0] a, input logic [31:0] b,
                                         input logic [31:0] m);
      return (a & m) == (b & m);
   endfunction

   logic instr_mode_ok;
   logic data_mode_ok;
   logic instr_hit;
   logic store_hit;
   logic load_addr_hit;
   logic load_hit;
   logic load_value_hit;
   logic load_value_late;
   logic instr_event;
   logic data_event;
   logic raise_exception;
   logic fire_trigger;
   logic exc_allowed;

   assign instr_mode_ok = mode_enabled(bp_control_reg[`BIT_INSTR_USER_EN],
      bp_control_reg[`BIT_INSTR_SUPERVISOR_EN], bp_control_reg[`BIT_INSTR_KERNEL_EN],
      bp_control_reg[`BIT_INSTR_EXC_LEVEL_EN], PRIV_MODE, EXCEPTION_LEVEL_FLAG,
      ERROR_LEVEL_FLAG);
   assign data_mode_ok = mode_enabled(bp_control_reg[`BIT_DATA_USER_EN],
      bp_control_reg[`BIT_DATA_SUPERVISOR_EN], bp_control_reg[`BIT_DATA_KERNEL_EN],
      bp_control_reg[`BIT_DATA_EXC_LEVEL_EN], PRIV_MODE, EXCEPTION_LEVEL_FLAG,
      ERROR_LEVEL_FLAG);

   assign instr_hit = FETCH_VALID && bp_control_reg[`BIT_INSTR_BP_ENABLE] && instr_mode_ok
      && masked_equal(instr_addr_compare, FETCH_PC, instr_addr_mask);

   assign store_hit = STORE_VALID && bp_control_reg[`BIT_STORE_BP_ENABLE] && data_mode_ok
      && masked_equal(data_addr_compare, ACCESS_ADDR, data_addr_mask)
      && (!bp_control_reg[`BIT_VALUE_QUALIFY]
          || masked_equal(data_value_compare, STORE_DATA[31:0], data_value_mask));

   // Without value qualification a load matches on address at issue.
   assign load_addr_hit = LOAD_VALID && bp_control_reg[`BIT_LOAD_BP_ENABLE] && data_mode_ok
      && !bp_control_reg[`BIT_VALUE_QUALIFY]
      && masked_equal(data_addr_compare, ACCESS_ADDR, data_addr_mask);

   // With qualification the load is judged when its data returns, already extended.
   assign load_value_hit = LOAD_DATA_VALID && bp_control_reg[`BIT_LOAD_BP_ENABLE]
      && data_mode_ok && bp_control_reg[`BIT_VALUE_QUALIFY]
      && masked_equal(data_addr_compare, LOAD_ADDR, data_addr_mask)
      && masked_equal(data_value_compare, LOAD_DATA[31:0], data_value_mask);

   assign load_hit = load_addr_hit || load_value_hit;
   assign load_value_late = (pend_state == hwbp_pkg::PEND_HELD) && !LEVEL2_MODE;

   assign instr_event = instr_hit;
   assign data_event = store_hit || load_hit;
   assign exc_allowed = !bp_control_reg[`BIT_EXCEPTION_DISABLE] && !LEVEL2_MODE;
   assign raise_exception = exc_allowed && (instr_event || store_hit || load_addr_hit
      || (load_value_hit && !LEVEL2_MODE) || load_value_late);
   assign fire_trigger = (instr_event && bp_control_reg[`BIT_INSTR_TRIGGER_EN])
      || (data_event && bp_control_reg[`BIT_DATA_TRIGGER_EN]);

   // A value break on a load that lands while in level two is held until level two ends.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         pend_state <= hwbp_pkg::PEND_IDLE;
      end else begin
         case (pend_state)
            hwbp_pkg::PEND_IDLE: begin
               if (load_value_hit && LEVEL2_MODE && !bp_control_reg[`BIT_EXCEPTION_DISABLE]) begin
                  pend_state <= hwbp_pkg::PEND_HELD;
               end
            end
            hwbp_pkg::PEND_HELD: begin
               if (!LEVEL2_MODE) begin
                  pend_state <= hwbp_pkg::PEND_IDLE;
               end
            end
            default: pend_state <= hwbp_pkg::PEND_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         bp_control_reg <= `CONTROL_RESET;
      end else begin
         if (REG_WRITE && REG_SELECT == `SEL_CONTROL) begin
            bp_control_reg <= REG_WDATA & `CONTROL_WRITABLE;
         end
         // Hardware set wins over a software write in the same cycle.
         if (instr_event) begin
            bp_control_reg[`BIT_INSTR_MATCH] <= 1'b1;
         end
         if (store_hit) begin
            bp_control_reg[`BIT_STORE_MATCH] <= 1'b1;
         end
         if (load_hit) begin
            bp_control_reg[`BIT_LOAD_MATCH] <= 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         instr_addr_compare <= `REG_RESET;
         instr_addr_mask <= `REG_RESET;
         data_addr_compare <= `REG_RESET;
         data_addr_mask <= `REG_RESET;
         data_value_compare <= `REG_RESET;
         data_value_mask <= `REG_RESET;
      end else if (REG_WRITE) begin
         case (REG_SELECT)
            `SEL_INSTR_COMPARE: instr_addr_compare <= REG_WDATA & `WORD_ALIGN_MASK;
            `SEL_INSTR_MASK: instr_addr_mask <= REG_WDATA & `WORD_ALIGN_MASK;
            `SEL_DATA_ADDR_COMPARE: data_addr_compare <= REG_WDATA;
            `SEL_DATA_ADDR_MASK: data_addr_mask <= REG_WDATA;
            `SEL_DATA_VALUE_COMPARE: data_value_compare <= REG_WDATA;
            `SEL_DATA_VALUE_MASK: data_value_mask <= REG_WDATA;
            default: ;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= `REG_RESET;
      end else if (REG_READ) begin
         case (REG_SELECT)
            `SEL_CONTROL: REG_RDATA <= bp_control_reg;
            `SEL_INSTR_COMPARE: REG_RDATA <= instr_addr_compare;
            `SEL_INSTR_MASK: REG_RDATA <= instr_addr_mask;
            `SEL_DATA_ADDR_COMPARE: REG_RDATA <= data_addr_compare;
            `SEL_DATA_ADDR_MASK: REG_RDATA <= data_addr_mask;
            `SEL_DATA_VALUE_COMPARE: REG_RDATA <= data_value_compare;
            `SEL_DATA_VALUE_MASK: REG_RDATA <= data_value_mask;
            default: REG_RDATA <= `REG_RESET;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         BREAK_EXCEPTION <= 1'b0;
      end else begin
         BREAK_EXCEPTION <= raise_exception;
      end
   end

   // A new trigger while one runs restarts the two-cycle pulse.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         trigger_count <= 2'h0;
         PROBE_TRIGGER_OUT <= 1'b0;
      end else if (fire_trigger) begin
         trigger_count <= `TRIGGER_CYCLES - 2'h1;
         PROBE_TRIGGER_OUT <= 1'b1;
      end else if (trigger_count != 2'h0) begin
         trigger_count <= trigger_count - 2'h1;
         PROBE_TRIGGER_OUT <= 1'b1;
      end else begin
         PROBE_TRIGGER_OUT <= 1'b0;
      end
   end

endmodule

// file: hwbp_defs.svh
// Constants for the hardware breakpoint unit: register selects, field positions, counts.
// Assumes inclusion by bare name from the design file.
`ifndef HWBP_DEFS_SVH
`define HWBP_DEFS_SVH

`define SEL_CONTROL 3'h0
`define SEL_INSTR_COMPARE 3'h1
`define SEL_INSTR_MASK 3'h2
`define SEL_DATA_ADDR_COMPARE 3'h3
`define SEL_DATA_ADDR_MASK 3'h4
`define SEL_DATA_VALUE_COMPARE 3'h5
`define SEL_DATA_VALUE_MASK 3'h6

`define BIT_INSTR_BP_ENABLE 31
`define BIT_LOAD_BP_ENABLE 30
`define BIT_STORE_BP_ENABLE 29
`define BIT_VALUE_QUALIFY 28
`define BIT_INSTR_USER_EN 26
`define BIT_INSTR_SUPERVISOR_EN 25
`define BIT_INSTR_KERNEL_EN 24
`define BIT_INSTR_EXC_LEVEL_EN 23
`define BIT_DATA_USER_EN 21
`define BIT_DATA_SUPERVISOR_EN 20
`define BIT_DATA_KERNEL_EN 19
`define BIT_DATA_EXC_LEVEL_EN 18
`define BIT_INSTR_TRIGGER_EN 17
`define BIT_DATA_TRIGGER_EN 16
`define BIT_EXCEPTION_DISABLE 15
`define BIT_STORE_MATCH 2
`define BIT_LOAD_MATCH 1
`define BIT_INSTR_MATCH 0

// Bits of the control register that hold storage; all others read zero.
`define CONTROL_WRITABLE 32'hf7bf8007
`define CONTROL_RESET 32'h00000000
`define WORD_ALIGN_MASK 32'hfffffffc
`define REG_RESET 32'h00000000

// Trigger pulse length in core clocks (core clock taken as the bus clock).
`define TRIGGER_CYCLES 2'h2

`endif

// file: hwbp_pkg.sv
// Types shared by the hardware breakpoint unit.
// Assumes nothing of its surroundings.
package hwbp_pkg;
   typedef enum logic [1:0] {
      MODE_KERNEL = 2'b00,
      MODE_SUPERVISOR = 2'b01,
      MODE_USER = 2'b10
   } priv_mode_t;

   typedef enum logic {
      PEND_IDLE = 1'b0,
      PEND_HELD = 1'b1
   } pend_state_t;
endpackage

// file: hwbp_check_sva.sv
// Port checker for the hardware breakpoint unit.
// Assumes it is bound to the unit and shares its MCLK and RSTN.
`timescale 1ns/100ps
module hwbp_check (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic REG_READ,
   input wire logic [2:0] REG_SELECT,
   input wire logic [31:0] REG_RDATA,
   input wire logic FETCH_VALID,
   input wire logic LOAD_VALID,
   input wire logic STORE_VALID,
   input wire logic LOAD_DATA_VALID,
   input wire logic LEVEL2_MODE,
   input wire logic BREAK_EXCEPTION,
   input wire logic PROBE_TRIGGER_OUT
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   wire anyv = FETCH_VALID | LOAD_VALID | STORE_VALID | LOAD_DATA_VALID;
   sequence quiet_high;
      PROBE_TRIGGER_OUT && !anyv;
   endsequence
   a_pulse_width: assert property ($rose(PROBE_TRIGGER_OUT) |=> PROBE_TRIGGER_OUT)
      else $error("trigger pulse too short");
   a_pulse_end: assert property (quiet_high [*2] |=> !PROBE_TRIGGER_OUT)
      else $error("trigger pulse too long");
   a_pulse_cause: assert property ($rose(PROBE_TRIGGER_OUT) |-> $past(anyv))
      else $error("trigger without access");
   a_exc_level2: assert property (BREAK_EXCEPTION |-> !$past(LEVEL2_MODE))
      else $error("exception inside level two");
   a_exc_cause: assert property (BREAK_EXCEPTION |-> $past(anyv) || $past(LEVEL2_MODE, 2))
      else $error("exception without access");
   a_rsvd_zero: assert property ($past(REG_READ) && $past(REG_SELECT) == 3'h0 |->
      REG_RDATA[14:3] == 12'h0 && !REG_RDATA[27] && !REG_RDATA[22])
      else $error("reserved control bits set");
   a_instr_low: assert property ($past(REG_READ) && $past(REG_SELECT) inside {3'h1, 3'h2} |->
      REG_RDATA[1:0] == 2'h0)
      else $error("instruction low bits set");
   a_unmapped_zero: assert property ($past(REG_READ) && $past(REG_SELECT) == 3'h7 |->
      REG_RDATA == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!$past(REG_READ) |-> $stable(REG_RDATA))
      else $error("read data moved");
endmodule

// file: pipe_model.sv
// Model of the fetch and load/store side that feeds the breakpoint unit.
// Assumes the bench calls its tasks; signals change at falling edges.
`timescale 1ns/100ps
module pipe_model (
   input wire logic MCLK,
   output logic FETCH_VALID,
   output logic [31:0] FETCH_PC,
   output logic LOAD_VALID,
   output logic STORE_VALID,
   output logic [31:0] ACCESS_ADDR,
   output logic [63:0] STORE_DATA,
   output logic LOAD_DATA_VALID,
   output logic [31:0] LOAD_ADDR,
   output logic [63:0] LOAD_DATA,
   output logic [1:0] PRIV_MODE,
   output logic EXCEPTION_LEVEL_FLAG,
   output logic ERROR_LEVEL_FLAG,
   output logic LEVEL2_MODE
);
   initial begin
      {FETCH_VALID, LOAD_VALID, STORE_VALID, LOAD_DATA_VALID} = 4'h0;
      {FETCH_PC, ACCESS_ADDR, LOAD_ADDR, STORE_DATA, LOAD_DATA} = 224'h0;
      {PRIV_MODE, EXCEPTION_LEVEL_FLAG, ERROR_LEVEL_FLAG, LEVEL2_MODE} = 5'h0;
   end
   // Kind 0 fetch, 1 store, 2 returning load data (already extended), 3 load issue.
   task automatic go(input int k, input logic [31:0] a, input logic [63:0] d);
      @(negedge MCLK);
      FETCH_VALID = k == 0;
      STORE_VALID = k == 1;
      LOAD_DATA_VALID = k == 2;
      LOAD_VALID = k == 3;
      {FETCH_PC, ACCESS_ADDR, LOAD_ADDR} = {a, a, a};
      {STORE_DATA, LOAD_DATA} = {d, d};
      @(negedge MCLK);
      {FETCH_VALID, LOAD_VALID, STORE_VALID, LOAD_DATA_VALID} = 4'h0;
      // Released lines show the inverse so stale values cannot match.
      {FETCH_PC, ACCESS_ADDR, LOAD_ADDR} = {~a, ~a, ~a};
      {STORE_DATA, LOAD_DATA} = {~d, ~d};
   endtask
   task automatic mode(input logic [1:0] m, input logic x, input logic l2, input logic e = 1'b0);
      @(negedge MCLK);
      PRIV_MODE = m;
      EXCEPTION_LEVEL_FLAG = x;
      ERROR_LEVEL_FLAG = e;
      LEVEL2_MODE = l2;
   endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the breakpoint unit driven by the pipeline model.
// Assumes the unit, checker and model files are compiled first.
`timescale 1ns/100ps
module tb_top;
   logic MCLK = 1'h0, RSTN = 1'h0, REG_WRITE = 1'h0, REG_READ = 1'h0;
   logic [2:0] REG_SELECT = 3'h0;
   logic [31:0] REG_WDATA = 32'h0, REG_RDATA, FETCH_PC, ACCESS_ADDR, LOAD_ADDR;
   logic [63:0] STORE_DATA, LOAD_DATA;
   logic FETCH_VALID, LOAD_VALID, STORE_VALID, LOAD_DATA_VALID, EXCEPTION_LEVEL_FLAG;
   logic ERROR_LEVEL_FLAG, LEVEL2_MODE, BREAK_EXCEPTION, PROBE_TRIGGER_OUT;
   logic [1:0] PRIV_MODE;
   logic [31:0] rb [8] = '{32'hf7bf8007, 32'hfffffffc, 32'hfffffffc, 32'hffffffff,
      32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h0};
   logic [1:0] ms [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
   int err_total = 0;
   int n_checks = 0;
   always #25 MCLK = ~MCLK;
   hardware_breakpoint_unit u_dut (.MCLK, .RSTN, .REG_WRITE, .REG_READ, .REG_SELECT,
      .REG_WDATA, .REG_RDATA, .FETCH_VALID, .FETCH_PC, .LOAD_VALID, .STORE_VALID,
      .ACCESS_ADDR, .STORE_DATA, .LOAD_DATA_VALID, .LOAD_ADDR, .LOAD_DATA, .PRIV_MODE,
      .EXCEPTION_LEVEL_FLAG, .ERROR_LEVEL_FLAG, .LEVEL2_MODE, .BREAK_EXCEPTION,
      .PROBE_TRIGGER_OUT);
   pipe_model u_pipe (.MCLK, .FETCH_VALID, .FETCH_PC, .LOAD_VALID, .STORE_VALID,
      .ACCESS_ADDR, .STORE_DATA, .LOAD_DATA_VALID, .LOAD_ADDR, .LOAD_DATA, .PRIV_MODE,
      .EXCEPTION_LEVEL_FLAG, .ERROR_LEVEL_FLAG, .LEVEL2_MODE);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [31:0] d);
      @(negedge MCLK);
      {REG_WRITE, REG_SELECT, REG_WDATA} = {1'h1, s, d};
      @(negedge MCLK);
      REG_WRITE = 1'h0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [31:0] e);
      @(negedge MCLK);
      {REG_READ, REG_SELECT} = {1'h1, s};
      @(negedge MCLK);
      REG_READ = 1'h0;
      chk(REG_RDATA, e);
   endtask
   // Exception and trigger one cycle after the access, trigger gone after two.
   task automatic hit(input logic e, input logic t);
      chk(32'({BREAK_EXCEPTION, PROBE_TRIGGER_OUT}), 32'({e, t}));
      @(negedge MCLK);
      chk(32'(PROBE_TRIGGER_OUT), 32'(t));
      @(negedge MCLK);
      chk(32'({BREAK_EXCEPTION, PROBE_TRIGGER_OUT}), 32'h0);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge MCLK);
      RSTN = 1'h1;
      for (int i = 0; i < 8; i++) rd(3'(i), 32'h0);
      for (int i = 0; i < 8; i++) wr(3'(i), 32'hffffffff);
      for (int i = 0; i < 8; i++) rd(3'(i), rb[i]);
      $display("test registers done");
      wr(3'h0, 32'h0);
      @(negedge MCLK);
      wr(3'h1, 32'h12345678);
      wr(3'h2, 32'hffffff00);
      wr(3'h0, 32'h84020000);
      u_pipe.mode(2'h2, 1'h0, 1'h0);
      u_pipe.go(0, 32'h123456fc, 64'h0);
      hit(1'h1, 1'h1);
      rd(3'h0, 32'h84020001);
      u_pipe.go(0, 32'h12345778, 64'h0);
      hit(1'h0, 1'h0);
      wr(3'h0, 32'h84000000);
      u_pipe.go(0, 32'h12345600, 64'h0);
      hit(1'h1, 1'h0);
      u_pipe.mode(2'h1, 1'h0, 1'h0);
      u_pipe.go(0, 32'h12345600, 64'h0);
      hit(1'h0, 1'h0);
      $display("test instruction done");
      wr(3'h3, 32'h12300000);
      wr(3'h4, 32'hfffc0000);
      for (int i = 0; i < 4; i++) begin
         wr(3'h0, 32'h20000000 | (32'h200000 >> i));
         u_pipe.mode(ms[i], i == 3, 1'h0);
         u_pipe.go(1, 32'h1233fff0, 64'h0);
         hit(1'h1, 1'h0);
      end
      u_pipe.mode(2'h0, 1'h0, 1'h0);
      u_pipe.go(1, 32'h1233fff0, 64'h0);
      hit(1'h0, 1'h0);
      wr(3'h0, 32'h40080000);
      u_pipe.go(3, 32'h12300010, 64'h0);
      hit(1'h1, 1'h0);
      rd(3'h0, 32'h40080002);
      u_pipe.mode(2'h0, 1'h0, 1'h0, 1'h1);
      u_pipe.go(3, 32'h12300010, 64'h0);
      hit(1'h0, 1'h0);
      $display("test data modes done");
      wr(3'h5, 32'hbabecafe);
      wr(3'h6, 32'h0000ffff);
      wr(3'h0, 32'h30118000);
      u_pipe.mode(2'h1, 1'h0, 1'h0);
      u_pipe.go(1, 32'h12300004, 64'h5555aaaa0000cafe);
      hit(1'h0, 1'h1);
      rd(3'h0, 32'h30118004);
      u_pipe.go(1, 32'h12300004, 64'h0000cafe0000beef);
      hit(1'h0, 1'h0);
      u_pipe.go(1, 32'h12400004, 64'h000000000000cafe);
      hit(1'h0, 1'h0);
      wr(3'h0, 32'h50080000);
      u_pipe.mode(2'h0, 1'h0, 1'h0);
      u_pipe.go(3, 32'h12300008, 64'h0);
      hit(1'h0, 1'h0);
      u_pipe.mode(2'h0, 1'h0, 1'h1);
      u_pipe.go(2, 32'h12300008, 64'hffffffffffffcafe);
      hit(1'h0, 1'h0);
      u_pipe.mode(2'h0, 1'h0, 1'h0);
      @(negedge MCLK);
      chk(32'(BREAK_EXCEPTION), 32'h1);
      @(negedge MCLK);
      chk(32'(BREAK_EXCEPTION), 32'h0);
      rd(3'h0, 32'h50080002);
      $display("test data value done");
      @(negedge MCLK);
      RSTN = 1'h0;
      @(negedge MCLK);
      RSTN = 1'h1;
      rd(3'h0, 32'h0);
      $display("test reset done");
      results();
   end
   initial begin
      repeat (5000) @(posedge MCLK);
      err_total++;
      $display("MISMATCH %0t run did not finish", $time);
      results();
   end
endmodule
bind hardware_breakpoint_unit hwbp_check u_chk (.MCLK, .RSTN, .REG_READ, .REG_SELECT,
   .REG_RDATA, .FETCH_VALID, .LOAD_VALID, .STORE_VALID, .LOAD_DATA_VALID, .LEVEL2_MODE,
   .BREAK_EXCEPTION, .PROBE_TRIGGER_OUT);
